// file: dv/oe_pin_host.sv
`timescale 1ns/100ps
module oe_pin_host (
    // clock
    input wire logic clk,
    // host side
    input wire logic drive,
    input wire logic level,
    // device pad resistors
    input wire logic pullUp,
    input wire logic pullDown,
    // pin
    output logic pin
);
    logic last_r = 1'b0;
    // a floating pin must not hold the old level, so it toggles
    always_ff @(posedge clk) begin
        last_r <= pin;
    end
    assign pin = drive ? level : pullUp ? 1'b1 :
        pullDown ? 1'b0 : ~last_r;
endmodule : oe_pin_host

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic regWrite = 1'b0;
    logic [1:0] regIndex = 2'h0;
    logic [31:0] regWdata = 32'h0;
    logic spiMode = 1'b0;
    logic startupActive = 1'b0;
    logic pllLock = 1'b0;
    logic forceDisable = 1'b0;
    logic driverPowerDown = 1'b0;
    oe_io_cfg_pkg::dis_state_t disState = oe_io_cfg_pkg::DIS_LOW_LOW;
    logic hostDrive = 1'b1;
    logic hostLevel = 1'b1;
    logic pin;
    logic [31:0] rdata;
    oe_io_cfg_pkg::drive_cfg_t driveCfg;
    oe_io_cfg_pkg::pad_cfg_t padCfg;
    oe_io_cfg_pkg::drv_ctrl_t drvCtrl;
    int nMismatch = 0;
    int checksDone = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    oe_pin_host host (.clk(clk), .drive(hostDrive), .level(hostLevel),
        .pullUp(padCfg.enablePinPullup),
        .pullDown(padCfg.enablePinPulldown), .pin(pin));
    output_enable_io_config uut (.clk(clk), .nrst(nrst),
        .regWrite(regWrite), .regIndex(regIndex), .regWdata(regWdata),
        .regRdata_r(rdata), .enableOrChipSelectPin(pin),
        .spiMode(spiMode), .startupActive(startupActive),
        .pllLock(pllLock), .forceDisable(forceDisable),
        .driverPowerDown(driverPowerDown), .disState(disState),
        .driveCfg_r(driveCfg), .padCfg_r(padCfg), .drvCtrl_r(drvCtrl));
    task end_sim;
        if (nMismatch == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [1:0] i, input logic [31:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regIndex = i;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask : wr
    task rd(input logic [1:0] i, input logic [31:0] exp);
        @(negedge clk);
        regIndex = i;
        repeat (2) @(negedge clk);
        chk(rdata, exp);
    endtask : rd
    // drive path has one cycle of latency; three covers register writes too
    task dis(input logic e);
        repeat (3) @(negedge clk);
        chk({31'h0, drvCtrl.driverDisable}, {31'h0, e});
    endtask : dis
    task t_reset_values;
        rd(oe_io_cfg_pkg::IDX_AMP, 32'h0000_00B4);
        rd(oe_io_cfg_pkg::IDX_DIV, 32'h0040_0000);
        rd(oe_io_cfg_pkg::IDX_OE, 32'h0000_0010);
        rd(oe_io_cfg_pkg::IDX_IO, 32'h0000_002F);
        chk({21'h0, driveCfg}, {21'h0, 4'hB, 3'h1, 2'h2, 2'h3});
        chk({28'h0, padCfg}, 32'h7);
    endtask : t_reset_values
    task t_fields;
        wr(oe_io_cfg_pkg::IDX_AMP, 32'h0000_00F8);
        wr(oe_io_cfg_pkg::IDX_DIV, 32'hFFFF_FFFF);
        rd(oe_io_cfg_pkg::IDX_DIV, 32'h0060_0000);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_00FF);
        rd(oe_io_cfg_pkg::IDX_OE, 32'h0000_0039);
        wr(oe_io_cfg_pkg::IDX_DIV, 32'h0);
        wr(oe_io_cfg_pkg::IDX_IO, 32'h0);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0020);
        repeat (3) @(negedge clk);
        chk({21'h0, driveCfg}, {21'h0, 4'hF, 3'h7, 4'h0});
        chk({28'h0, padCfg}, 32'h8);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0010);
        wr(oe_io_cfg_pkg::IDX_IO, 32'h0000_002F);
    endtask : t_fields
    task t_pin;
        dis(1'b0);
        hostLevel = 1'b0;
        dis(1'b1);
        spiMode = 1'b1;
        dis(1'b0);
        spiMode = 1'b0;
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0018);
        dis(1'b0);
        hostLevel = 1'b1;
        dis(1'b1);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0019);
        dis(1'b0);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0010);
        hostDrive = 1'b0;
        dis(1'b0);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0020);
        dis(1'b1);
        wr(oe_io_cfg_pkg::IDX_OE, 32'h0000_0010);
        hostDrive = 1'b1;
    endtask : t_pin
    task t_startup;
        startupActive = 1'b1;
        dis(1'b1);
        pllLock = 1'b1;
        dis(1'b0);
        pllLock = 1'b0;
        wr(oe_io_cfg_pkg::IDX_IO, 32'h0000_00AF);
        dis(1'b0);
        forceDisable = 1'b1;
        dis(1'b1);
    endtask : t_startup
    task t_power;
        disState = oe_io_cfg_pkg::DIS_RUNNING;
        dis(1'b0);
        disState = oe_io_cfg_pkg::DIS_HIZ;
        dis(1'b1);
        disState = oe_io_cfg_pkg::DIS_LOW_HIGH;
        dis(1'b1);
        chk({30'h0, drvCtrl.padLevel}, 32'h1);
        driverPowerDown = 1'b1;
        dis(1'b0);
        chk({31'h0, drvCtrl.tristate}, 32'h1);
    endtask : t_power
    // the whole sequence takes about a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            nMismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        t_reset_values();
        t_fields();
        t_pin();
        t_startup();
        t_power();
        end_sim();
    end
endmodule : tb

// file: hw/oe_io_cfg_pkg.sv
package oe_io_cfg_pkg;

    // register indices; the printed map gives no offsets, so these are
    // local indices on the documented register port
    localparam logic [1:0] IDX_AMP = 2'h0;
    localparam logic [1:0] IDX_DIV = 2'h1;
    localparam logic [1:0] IDX_OE = 2'h2;
    localparam logic [1:0] IDX_IO = 2'h3;

    // field positions
    localparam int SWING_LSB = 4;
    localparam int LVDS_AMP_BIT = 3;
    localparam int DIV_SETN_BIT = 22;
    localparam int DIV_ENN_BIT = 21;
    localparam int PIN_PD_BIT = 5;
    localparam int PIN_PU_BIT = 4;
    localparam int OE_POL_BIT = 3;
    localparam int OE_SEL_BIT = 0;
    localparam int STARTUP_LSB = 6;
    localparam int PP_LSB = 4;
    localparam int OD_LSB = 2;
    localparam int DATA_PU_BIT = 1;
    localparam int CLK_PU_BIT = 0;

    // reset values
    localparam logic [7:0] AMP_RST = 8'hB4;
    localparam logic [31:0] DIV_RST = 32'h0040_0000;
    localparam logic [7:0] OE_RST = 8'h10;
    localparam logic [7:0] IO_RST = 8'h2F;

    // writable masks; reserved RO bits read as zero
    localparam logic [31:0] DIV_WMASK = 32'h0060_0000;
    localparam logic [7:0] OE_WMASK = 8'h39;

    localparam logic [1:0] STARTUP_GATED = 2'h0;
    localparam logic [1:0] STARTUP_FREE = 2'h2;

    typedef enum logic [1:0] {
        DIS_LOW_LOW,
        DIS_LOW_HIGH,
        DIS_HIZ,
        DIS_RUNNING
    } dis_state_t;

    typedef struct packed {
        logic [3:0] swing;
        logic lvdsAmpHigh;
        logic divHoldSet;
        logic divEnable;
        logic [1:0] pushPullStrength;
        logic [1:0] openDrainStrength;
    } drive_cfg_t;

    typedef struct packed {
        logic enablePinPulldown;
        logic enablePinPullup;
        logic serialDataPullup;
        logic serialClockPullup;
    } pad_cfg_t;

    typedef struct packed {
        logic driverDisable;
        logic tristate;
        logic [1:0] padLevel;
    } drv_ctrl_t;

endpackage : oe_io_cfg_pkg

// file: hw/output_enable_io_config.sv
// Notes on behaviour
// - 4-bit swing field 7:4, 200mV at 0x0 to 900mV at 0xF, resets 0xB.
// - lvds amplitude bit: 0 gives 350mV, 1 gives 400mV, resets 0.
// - divider set bit 22 active low holds divider set; resets one.
// - divider enable bit 21 active low enables divider; resets zero.
// - polarity: 0 high level enables, 1 low level enables; pin mode only.
// - select 0: deasserted enable pin disables clock output drivers.
// - in SPI mode the pin is chip select and pin enable is ignored.
// - select 1: enable pin level has no effect on drivers.
// - startup field 0x0: drivers disabled during startup until PLL lock.
// - startup field 0x2: no lock gating; codes 0x1, 0x3 reserved.
// - bit 5 switches on enable pin pull-down; resets zero.
// - bit 4 switches on enable pin pull-up; resets one.
// - push-pull strength 5:4 resets 0x2, higher is stronger.
// - open-drain strength 3:2 resets 0x3, higher is stronger.
// - bit 1 enables serial data pin pull-up; resets one.
// - bit 0 enables serial clock pin pull-up; resets one.
// - disabled driver holds pins per disabled-state field.
// - powered-down driver tri-stated, all enable controls ignored.
`timescale 1ns/100ps
module output_enable_io_config (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic regWrite,
    input wire logic [1:0] regIndex,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata_r,
    // device state
    input wire logic enableOrChipSelectPin,
    input wire logic spiMode,
    input wire logic startupActive,
    input wire logic pllLock,
    input wire logic forceDisable,
    input wire logic driverPowerDown,
    input wire oe_io_cfg_pkg::dis_state_t disState,
    // configuration outputs
    output oe_io_cfg_pkg::drive_cfg_t driveCfg_r,
    output oe_io_cfg_pkg::pad_cfg_t padCfg_r,
    output oe_io_cfg_pkg::drv_ctrl_t drvCtrl_r
);

    logic [7:0] ampReg_r;
    logic [31:0] divReg_r;
    logic [7:0] oeReg_r;
    logic [7:0] ioReg_r;
    logic pinDisable;
    logic startGate;
    logic disableAny;
    logic [1:0] startupCode;
    oe_io_cfg_pkg::drv_ctrl_t drvCtrl_nxt;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ampReg_r <= oe_io_cfg_pkg::AMP_RST;
        end else if (regWrite && regIndex == oe_io_cfg_pkg::IDX_AMP) begin
            ampReg_r <= regWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            divReg_r <= oe_io_cfg_pkg::DIV_RST;
        end else if (regWrite && regIndex == oe_io_cfg_pkg::IDX_DIV) begin
            divReg_r <= regWdata & oe_io_cfg_pkg::DIV_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            oeReg_r <= oe_io_cfg_pkg::OE_RST;
        end else if (regWrite && regIndex == oe_io_cfg_pkg::IDX_OE) begin
            oeReg_r <= regWdata[7:0] & oe_io_cfg_pkg::OE_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ioReg_r <= oe_io_cfg_pkg::IO_RST;
        end else if (regWrite && regIndex == oe_io_cfg_pkg::IDX_IO) begin
            ioReg_r <= regWdata[7:0];
        end
    end

    // read data registered so the port output comes from a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdata_r <= 32'h0000_0000;
        end else begin
            case (regIndex)
                oe_io_cfg_pkg::IDX_AMP: regRdata_r <= {24'h00_0000, ampReg_r};
                oe_io_cfg_pkg::IDX_DIV: regRdata_r <= divReg_r;
                oe_io_cfg_pkg::IDX_OE: regRdata_r <= {24'h00_0000, oeReg_r};
                oe_io_cfg_pkg::IDX_IO: regRdata_r <= {24'h00_0000, ioReg_r};
                default: regRdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign startupCode = ioReg_r[oe_io_cfg_pkg::STARTUP_LSB +: 2];

    // pin level equal to polarity gives disable; spi mode owns the pin
    assign pinDisable = !oeReg_r[oe_io_cfg_pkg::OE_SEL_BIT] && !spiMode
        && (enableOrChipSelectPin == oeReg_r[oe_io_cfg_pkg::OE_POL_BIT]);

    // reserved codes behave as gated, the safer choice for startup
    assign startGate = startupActive && !pllLock
        && (startupCode != oe_io_cfg_pkg::STARTUP_FREE);

    assign disableAny = pinDisable || forceDisable || startGate;

    always_comb begin
        drvCtrl_nxt = '0;
        if (driverPowerDown) begin
            drvCtrl_nxt.tristate = 1'b1;
        end else if (disableAny) begin
            drvCtrl_nxt.driverDisable = 1'b1;
            case (disState)
                oe_io_cfg_pkg::DIS_LOW_LOW: drvCtrl_nxt.padLevel = 2'h0;
                oe_io_cfg_pkg::DIS_LOW_HIGH: drvCtrl_nxt.padLevel = 2'h1;
                oe_io_cfg_pkg::DIS_HIZ: drvCtrl_nxt.tristate = 1'b1;
                oe_io_cfg_pkg::DIS_RUNNING: drvCtrl_nxt.driverDisable = 1'b0;
                default: drvCtrl_nxt.tristate = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            drvCtrl_r <= '0;
        end else begin
            drvCtrl_r <= drvCtrl_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            driveCfg_r <= '0;
            padCfg_r <= '0;
        end else begin
            driveCfg_r.swing <= ampReg_r[oe_io_cfg_pkg::SWING_LSB +: 4];
            driveCfg_r.lvdsAmpHigh <= ampReg_r[oe_io_cfg_pkg::LVDS_AMP_BIT];
            driveCfg_r.divHoldSet <= !divReg_r[oe_io_cfg_pkg::DIV_SETN_BIT];
            driveCfg_r.divEnable <= !divReg_r[oe_io_cfg_pkg::DIV_ENN_BIT];
            driveCfg_r.pushPullStrength <= ioReg_r[oe_io_cfg_pkg::PP_LSB +: 2];
            driveCfg_r.openDrainStrength <=
                ioReg_r[oe_io_cfg_pkg::OD_LSB +: 2];
            padCfg_r.enablePinPulldown <= oeReg_r[oe_io_cfg_pkg::PIN_PD_BIT];
            padCfg_r.enablePinPullup <= oeReg_r[oe_io_cfg_pkg::PIN_PU_BIT];
            padCfg_r.serialDataPullup <= ioReg_r[oe_io_cfg_pkg::DATA_PU_BIT];
            padCfg_r.serialClockPullup <= ioReg_r[oe_io_cfg_pkg::CLK_PU_BIT];
        end
    end

    // checks
    logic pastValid_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pastValid_r <= 1'b0;
        end else begin
            pastValid_r <= 1'b1;
        end
    end

    // first sampled edge after reset release
    sequence justReset_s;
        !pastValid_r;
    endsequence

    sequence wrIdx_s(logic [1:0] idx);
        regWrite && regIndex == idx;
    endsequence

    sequence pinOff_s;
        !oeReg_r[0] && !spiMode && enableOrChipSelectPin == oeReg_r[3];
    endsequence

    // the driver is live and its disabled state is a static one
    sequence staticHold_s;
        !driverPowerDown && disState != 2'h3;
    endsequence

    sequence lockWait_s;
        startupActive && !pllLock;
    endsequence

    sequence pinIgnored_s;
        (oeReg_r[0] || spiMode) && !forceDisable && !startGate;
    endsequence

    a_amp_reset: assert property (@(posedge clk)
        disable iff (!nrst)
        justReset_s |-> ampReg_r[7:4] == 4'hB && !ampReg_r[3])
        else $error("amplitude register reset value wrong");

    a_amp_write: assert property (@(posedge clk)
        disable iff (!nrst)
        wrIdx_s(oe_io_cfg_pkg::IDX_AMP)
        |=> ampReg_r == $past(regWdata[7:0]))
        else $error("amplitude register write lost");

    a_swing_follow: assert property (@(posedge clk)
        disable iff (!nrst)
        pastValid_r |=> driveCfg_r.swing == $past(ampReg_r[7:4]))
        else $error("swing output not following register");

    a_lvds_follow: assert property (@(posedge clk)
        disable iff (!nrst)
        pastValid_r |=> driveCfg_r.lvdsAmpHigh == $past(ampReg_r[3]))
        else $error("lvds amplitude output not following register");

    a_div_reset: assert property (@(posedge clk)
        disable iff (!nrst)
        justReset_s |-> divReg_r[22] && !divReg_r[21])
        else $error("divider register reset value wrong");

    a_div_set: assert property (@(posedge clk)
        disable iff (!nrst)
        !divReg_r[22] |=> driveCfg_r.divHoldSet)
        else $error("divider not held set");

    a_div_release: assert property (@(posedge clk)
        disable iff (!nrst)
        divReg_r[22] |=> !driveCfg_r.divHoldSet)
        else $error("divider held set while bit high");

    a_div_enable: assert property (@(posedge clk)
        disable iff (!nrst)
        !divReg_r[21] |=> driveCfg_r.divEnable)
        else $error("divider not enabled");

    a_div_write: assert property (@(posedge clk)
        disable iff (!nrst)
        wrIdx_s(oe_io_cfg_pkg::IDX_DIV)
        |=> divReg_r == ($past(regWdata) & oe_io_cfg_pkg::DIV_WMASK))
        else $error("divider register write wrong");

    a_div_ro: assert property (@(posedge clk)
        disable iff (!nrst)
        (divReg_r & ~oe_io_cfg_pkg::DIV_WMASK) == 32'h0000_0000)
        else $error("divider read-only bits set");

    a_oe_reset: assert property (@(posedge clk)
        disable iff (!nrst)
        justReset_s |-> oeReg_r == oe_io_cfg_pkg::OE_RST)
        else $error("enable pin register reset value wrong");

    a_oe_ro: assert property (@(posedge clk)
        disable iff (!nrst)
        (oeReg_r & ~oe_io_cfg_pkg::OE_WMASK) == 8'h00)
        else $error("enable pin read-only bits set");

    a_io_reset: assert property (@(posedge clk)
        disable iff (!nrst)
        justReset_s |-> ioReg_r == oe_io_cfg_pkg::IO_RST)
        else $error("io register reset value wrong");

    a_io_write: assert property (@(posedge clk)
        disable iff (!nrst)
        wrIdx_s(oe_io_cfg_pkg::IDX_IO)
        |=> ioReg_r == $past(regWdata[7:0]))
        else $error("io register write lost");

    a_read_back: assert property (@(posedge clk)
        disable iff (!nrst)
        pastValid_r && regIndex == oe_io_cfg_pkg::IDX_IO
        |=> regRdata_r == {24'h00_0000, $past(ioReg_r)})
        else $error("io register read data wrong");

    a_pin_disable: assert property (@(posedge clk)
        disable iff (!nrst)
        pinOff_s and staticHold_s |=> drvCtrl_r.driverDisable)
        else $error("enable pin failed to disable driver");

    a_pin_enable: assert property (@(posedge clk)
        disable iff (!nrst)
        !oeReg_r[0] && !spiMode && enableOrChipSelectPin != oeReg_r[3]
        && !forceDisable && !startGate |=> !drvCtrl_r.driverDisable)
        else $error("asserted enable pin left driver disabled");

    a_pin_ignored: assert property (@(posedge clk)
        disable iff (!nrst)
        pinIgnored_s and spiMode |=> !drvCtrl_r.driverDisable)
        else $error("enable pin acted in spi mode");

    a_pin_select: assert property (@(posedge clk)
        disable iff (!nrst)
        pinIgnored_s and oeReg_r[0] |=> !drvCtrl_r.driverDisable)
        else $error("enable pin acted while deselected");

    a_startup_gate: assert property (@(posedge clk)
        disable iff (!nrst)
        lockWait_s and staticHold_s and ioReg_r[7:6] == 2'h0
        |=> drvCtrl_r.driverDisable)
        else $error("outputs not gated before lock");

    a_startup_free: assert property (@(posedge clk)
        disable iff (!nrst)
        ioReg_r[7:6] == 2'h2 && !pinDisable && !forceDisable
        |=> !drvCtrl_r.driverDisable)
        else $error("outputs gated although gating is off");

    a_reserved_gate: assert property (@(posedge clk)
        disable iff (!nrst)
        lockWait_s and staticHold_s and ioReg_r[6]
        |=> drvCtrl_r.driverDisable)
        else $error("reserved startup code not gated");

    a_pull_bits: assert property (@(posedge clk)
        disable iff (!nrst)
        pastValid_r |=> padCfg_r ==
        {$past(oeReg_r[5:4]), $past(ioReg_r[1:0])})
        else $error("pull configuration mismatch");

    a_strength: assert property (@(posedge clk)
        disable iff (!nrst)
        pastValid_r |=> {driveCfg_r.pushPullStrength,
        driveCfg_r.openDrainStrength} == $past(ioReg_r[5:2]))
        else $error("drive strength mismatch");

    a_hiz_state: assert property (@(posedge clk)
        disable iff (!nrst)
        disableAny && !driverPowerDown && disState == 2'h2
        |=> drvCtrl_r.tristate && drvCtrl_r.driverDisable)
        else $error("disabled driver not hi-z");

    a_low_high: assert property (@(posedge clk)
        disable iff (!nrst)
        disableAny && !driverPowerDown && disState == 2'h1
        |=> drvCtrl_r.padLevel == 2'h1 && !drvCtrl_r.tristate)
        else $error("disabled driver not held low/high");

    a_low_low: assert property (@(posedge clk)
        disable iff (!nrst)
        disableAny && !driverPowerDown && disState == 2'h0
        |=> drvCtrl_r.padLevel == 2'h0 && drvCtrl_r.driverDisable)
        else $error("disabled driver not held low/low");

    a_running: assert property (@(posedge clk)
        disable iff (!nrst)
        !driverPowerDown && disState == 2'h3
        |=> !drvCtrl_r.driverDisable && !drvCtrl_r.tristate)
        else $error("running disabled state held driver");

    a_power_down: assert property (@(posedge clk)
        disable iff (!nrst)
        driverPowerDown |=> drvCtrl_r.tristate && !drvCtrl_r.driverDisable)
        else $error("powered-down driver not tristated");

    a_force_dis: assert property (@(posedge clk)
        disable iff (!nrst)
        forceDisable && !driverPowerDown && disState == 2'h1
        |=> drvCtrl_r.driverDisable && drvCtrl_r.padLevel == 2'h1)
        else $error("force disable ignored");

    a_no_cause: assert property (@(posedge clk)
        disable iff (!nrst)
        !disableAny && !driverPowerDown |=> drvCtrl_r == '0)
        else $error("driver disabled without a cause");

endmodule : output_enable_io_config
